/* File: hdl/ddr_mode_burst.v */
// Device-side mode register, command decode and burst ordering of a x16
// double-data-rate SDRAM, with a small column store and an APB window.
// Assumes the link clock and all link pins are asynchronous to pclk and
// slow enough (several pclk periods per half cycle) to be edge-sampled.
//
// Overview of operation
// - Address 0..12 and bank bits are captured in the cycle the load is sampled.
// - Programmed mode contents hold until the next mode load.
// - Bits 2..0 give burst length: 001 two, 010 four, 011 eight; others reserved.
// - Bit 3 picks burst order type: 0 sequential, 1 interleaved.
// - Sequential bursts count up from start, wrapping inside the aligned block.
// - Interleaved bursts use start offset XOR beat count inside the block.
// - First read data comes CAS latency clocks after the read command.
// - Bits 6..4 give latency: 010 two, 011 three, 110 two and a half.
// - Bits 8..7 zero is normal; 10 asks DLL reset; bit 7 set is test mode.
// - bank_sel_bit_zero low targets mode register, high the extended one.
// - Commands decode with current and previous-cycle clock enable levels; the decode here uses only the previous-cycle level.
// - Low and high byte write masks act independently.
// - Low mask guards data bits 0..7, high mask guards bits 8..15.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "ddr_mode_defs.vh"

module ddr_mode_burst
#(
    parameter COL_BITS = 4
)
(
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ck,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] ba,
    input wire [12:0] addr,
    input wire low_byte_mask,
    input wire high_byte_mask,
    input wire [15:0] dq_in,
    output wire [15:0] dq_out,
    output wire dq_oe
);

    localparam DEPTH = 1 << COL_BITS;
    localparam PIN_W = 38;

    // ==========================================================
    // Synchronisers: every link pin passes two flops before use
    reg ck_s1_q, ck_s2_q, ck_s3_q;
    reg [PIN_W-1:0] pin_s1_q, pin_s2_q;
    wire [PIN_W-1:0] pin_raw = {cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                                low_byte_mask, high_byte_mask, dq_in};

    // Third ck flop only remembers the previous synchronised level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            pin_s1_q <= {PIN_W{1'b0}};
            pin_s2_q <= {PIN_W{1'b0}};
        end
        else
        begin
            ck_s1_q <= ck;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    wire ck_rise = ck_s2_q & ~ck_s3_q;
    wire ck_edge = ck_s2_q ^ ck_s3_q;
    wire s_cke = pin_s2_q[37];
    wire s_cs_n = pin_s2_q[36];
    wire s_ras_n = pin_s2_q[35];
    wire s_cas_n = pin_s2_q[34];
    wire s_we_n = pin_s2_q[33];
    wire [1:0] s_ba = pin_s2_q[32:31];
    wire [12:0] s_addr = pin_s2_q[30:18];
    wire s_lmask = pin_s2_q[17];
    wire s_hmask = pin_s2_q[16];
    wire [15:0] s_dq = pin_s2_q[15:0];

    // ==========================================================
    // Command decode on each link-clock rising edge
    reg cke_prev_q;
    reg [31:0] ctrl_q;
    // Previous clock enable gates every command; power-down exit decodes nothing
    wire cmd_ok = ck_rise & cke_prev_q & ~s_cs_n & ctrl_q[`CTRL_DECODE_EN_BIT];
    wire cmd_load = cmd_ok & ~s_ras_n & ~s_cas_n & ~s_we_n;
    wire cmd_mode = cmd_load & ~s_ba[0];
    wire cmd_ext = cmd_load & s_ba[0];
    wire cmd_read = cmd_ok & s_ras_n & ~s_cas_n & s_we_n;
    wire cmd_write = cmd_ok & s_ras_n & ~s_cas_n & ~s_we_n;
    wire cmd_stop = cmd_ok & s_ras_n & s_cas_n & ~s_we_n;

    // ==========================================================
    // Mode and extended mode registers
    reg [`MR_WIDTH-1:0] mode_q, ext_q;
    reg mode_valid_q, ext_valid_q;
    reg [1:0] settle_q;

    // Reset clears the contents to zero until loaded; the valid flags tell software
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cke_prev_q <= 1'b0;
            mode_q <= `MR_RESET;
            ext_q <= `MR_RESET;
            mode_valid_q <= 1'b0;
            ext_valid_q <= 1'b0;
            settle_q <= 2'h0;
        end
        else
        begin
            if (ck_rise)
                cke_prev_q <= s_cke;
            // Bank and address pins stored at the sampling edge, kept until next load
            if (cmd_mode)
            begin
                mode_q <= {s_ba, s_addr};
                mode_valid_q <= 1'b1;
            end
            if (cmd_ext)
            begin
                ext_q <= {s_ba, s_addr};
                ext_valid_q <= 1'b1;
            end
            // Settling window shown in status; the controller must respect it
            if (cmd_load)
                settle_q <= `MODE_SET_DELAY;
            else if (ck_rise && settle_q != 2'h0)
                settle_q <= settle_q - 2'h1;
        end
    end

    // ==========================================================
    // Field decode
    wire [2:0] bl_code = mode_q[`MR_BL_MSB:`MR_BL_LSB];
    wire [2:0] cl_code = mode_q[`MR_CL_MSB:`MR_CL_LSB];
    wire [1:0] tm_code = mode_q[`MR_TM_MSB:`MR_TM_LSB];
    wire interleave = mode_q[`MR_BT_BIT];
    reg [3:0] bl_beats;
    reg bl_rsvd;
    reg [4:0] cl_half;
    reg cl_rsvd;

    // Reserved codes fall back to the shortest setting and are flagged
    always @*
    begin
        bl_rsvd = 1'b0;
        case (bl_code)
            `BL_CODE_2: bl_beats = `BEATS_2;
            `BL_CODE_4: bl_beats = `BEATS_4;
            `BL_CODE_8: bl_beats = `BEATS_8;
            default:
            begin
                bl_beats = `BEATS_2;
                bl_rsvd = 1'b1;
            end
        endcase
        cl_rsvd = 1'b0;
        case (cl_code)
            `CL_CODE_2: cl_half = `CL_HALF_2;
            `CL_CODE_3: cl_half = `CL_HALF_3;
            `CL_CODE_25: cl_half = `CL_HALF_25;
            default:
            begin
                cl_half = `CL_HALF_2;
                cl_rsvd = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Burst engine, counting link-clock edges (both polarities)
    reg burst_q, rd_q, dq_oe_q;
    reg [4:0] half_q, target_q;
    reg [3:0] beats_q;
    reg order_q;
    reg [COL_BITS-1:0] start_q;
    reg [15:0] dq_out_q;
    reg [15:0] mem [0:DEPTH-1];

    wire [4:0] half_nx = half_q + 5'h01;
    wire [4:0] beat_w = half_nx - target_q;
    wire in_beat = burst_q && (half_nx >= target_q) && (beat_w < {1'b0, beats_q});
    wire last_beat = in_beat && (beat_w == {1'b0, beats_q} - 5'h01);
    wire [2:0] blk_mask = beats_q[3:1] - 3'h1 | beats_q[3:1];
    wire [2:0] low_bits = blk_mask & (order_q ? (start_q[2:0] ^ beat_w[2:0])
                                              : (start_q[2:0] + beat_w[2:0]));
    wire [2:0] base_bits = start_q[2:0] & ~blk_mask;
    wire [COL_BITS-1:0] col = {start_q[COL_BITS-1:3], base_bits | low_bits};

    // Burst start, beat timing, stop and data path
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            burst_q <= 1'b0;
            rd_q <= 1'b0;
            half_q <= 5'h00;
            target_q <= 5'h00;
            beats_q <= `BEATS_2;
            order_q <= 1'b0;
            start_q <= {COL_BITS{1'b0}};
            dq_oe_q <= 1'b0;
            dq_out_q <= 16'h0000;
        end
        else if (cmd_read || cmd_write)
        begin
            // Length and order are frozen per burst from the stored mode
            burst_q <= 1'b1;
            rd_q <= cmd_read;
            half_q <= 5'h00;
            target_q <= cmd_read ? cl_half : `WR_HALF;
            beats_q <= bl_beats;
            order_q <= interleave;
            start_q <= s_addr[COL_BITS-1:0];
            dq_oe_q <= 1'b0;
        end
        else if (cmd_stop)
        begin
            burst_q <= 1'b0;
            dq_oe_q <= 1'b0;
        end
        else if (ck_edge)
        begin
            half_q <= half_nx;
            dq_oe_q <= in_beat & rd_q;
            if (in_beat && rd_q)
                dq_out_q <= mem[col];
            if (last_beat)
                burst_q <= 1'b0;
        end
    end

    // Column store; masked lanes keep their old contents
    always @(posedge pclk)
    begin
        if (ck_edge && in_beat && !rd_q && !cmd_read && !cmd_write && !cmd_stop)
        begin
            if (!s_lmask)
                mem[col][7:0] <= s_dq[7:0];
            if (!s_hmask)
                mem[col][15:8] <= s_dq[15:8];
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;

    // ==========================================================
    // Status flags
    reg dll_reset_q;
    wire st_wr = psel & penable & pwrite & (paddr == `REG_STATUS);

    // DLL reset request is sticky; a new request wins over a software clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dll_reset_q <= 1'b0;
        else if (cmd_mode && s_addr[`MR_TM_MSB:`MR_TM_LSB] == `TM_DLL_RESET)
            dll_reset_q <= 1'b1;
        else if (st_wr && pwdata[`ST_DLL_RESET])
            dll_reset_q <= 1'b0;
    end

    wire [31:0] status_w = {24'h000000, (settle_q != 2'h0), burst_q, dll_reset_q,
                            tm_code[0], cl_rsvd, bl_rsvd, ext_valid_q, mode_valid_q};

    // ==========================================================
    // APB slave: zero wait states, read data registered in setup
    reg [31:0] prdata_q;
    reg pslverr_q;
    reg [31:0] rd_mux;
    reg hit;

    always @*
    begin
        hit = 1'b1;
        case (paddr)
            `REG_MODE: rd_mux = {17'h00000, mode_q};
            `REG_EXT_MODE: rd_mux = {17'h00000, ext_q};
            `REG_STATUS: rd_mux = status_w;
            `REG_CTRL: rd_mux = ctrl_q;
            default:
            begin
                rd_mux = 32'h00000000;
                hit = 1'b0;
            end
        endcase
    end

    // Writes take effect in the access phase; mode registers are read only
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
            ctrl_q <= `CTRL_RESET;
        end
        else
        begin
            if (psel && !penable)
            begin
                prdata_q <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_q <= ~hit | (pwrite & (paddr == `REG_MODE || paddr == `REG_EXT_MODE));
            end
            if (psel && penable && pwrite && paddr == `REG_CTRL)
                ctrl_q <= {31'h00000000, pwdata[`CTRL_DECODE_EN_BIT]};
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

endmodule

/* File: hdl/ddr_mode_defs.vh */
// Constants for the mode-register and burst-order block: pin fields,
// mode-register field codes, latency figures and the APB register map.
// Assumes it is included by the bare name and holds definitions only.
`ifndef DDR_MODE_DEFS_VH
`define DDR_MODE_DEFS_VH

// ==========================================================
// Mode register fields (address pin positions)
`define MR_BL_LSB 0
`define MR_BL_MSB 2
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_CL_MSB 6
`define MR_TM_LSB 7
`define MR_TM_MSB 8
`define MR_BA0_BIT 13
`define MR_BA1_BIT 14
`define MR_WIDTH 15
`define MR_RESET 15'h0000

// ==========================================================
// Field codes
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define CL_CODE_2 3'h2
`define CL_CODE_3 3'h3
`define CL_CODE_25 3'h6
`define TM_NORMAL 2'h0
`define TM_DLL_RESET 2'h2

// Latencies in half link-clock cycles (one per clock edge)
`define CL_HALF_2 5'h04
`define CL_HALF_25 5'h05
`define CL_HALF_3 5'h06
// Write data is taken from one link-clock cycle after the command
`define WR_HALF 5'h02

// Burst lengths as beat counts
`define BEATS_2 4'h2
`define BEATS_4 4'h4
`define BEATS_8 4'h8

// Least gap after a mode load, in link-clock cycles
`define MODE_SET_DELAY 2'h2

// ==========================================================
// APB register map (byte addresses)
`define REG_MODE 12'h000
`define REG_EXT_MODE 12'h004
`define REG_STATUS 12'h008
`define REG_CTRL 12'h00c
`define CTRL_RESET 32'h0000_0001
`define CTRL_DECODE_EN_BIT 0

// Status bit positions
`define ST_MODE_VALID 0
`define ST_EXT_VALID 1
`define ST_BL_RSVD 2
`define ST_CL_RSVD 3
`define ST_TEST_MODE 4
`define ST_DLL_RESET 5
`define ST_BURST 6
`define ST_SETTLING 7

`endif

/* File: test/ddr_mode_burst_sva.sv */
// Checker for the APB answer and link-edge timing of the read pins.
// Assumes a bind to ddr_mode_burst; ck is slow beside pclk.
`timescale 1ns/100ps
module ddr_mode_burst_sva
(
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire ck,
    input wire [15:0] dq_out,
    input wire dq_oe
);
    // ====
    // Age of the last ck move in pclk cycles; saturates so it never wraps
    logic ck_q;
    logic [3:0] age_q;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ck_q <= 1'b0;
            age_q <= 4'hf;
        end
        else
        begin
            ck_q <= ck;
            age_q <= (ck != ck_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_idle; !(psel && penable) |-> !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("error outside access");
    property p_map; psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0; endproperty
    a_map: assert property (p_map) else $error("unmapped access taken");
    property p_ro; psel && penable && pwrite && paddr < 12'h008 |-> pslverr; endproperty
    a_ro: assert property (p_ro) else $error("mode write taken");
    property p_ok; psel && penable && paddr[11:3] == 9'h001 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("good access refused");
    property p_one; pslverr |=> !pslverr; endproperty
    a_one: assert property (p_one) else $error("error held on");
    property p_dq; $changed(dq_out) |-> age_q <= 4'h6; endproperty
    a_dq: assert property (p_dq) else $error("data off a link edge");
    property p_oe; $changed(dq_oe) |-> age_q <= 4'h6; endproperty
    a_oe: assert property (p_oe) else $error("enable off a link edge");
    c_err: cover property (psel && penable && pslverr);
    c_beat: cover property (!dq_oe ##1 dq_oe);
    c_end: cover property (dq_oe ##1 !dq_oe);
endmodule

/* File: test/ddr_ctrl_model.sv */
// Controller model: free-running link clock, command pins, write bursts.
// Assumes pclk from the bench; pins move mid half-period, clear of ck edges.
`timescale 1ns/100ps
module ddr_ctrl_model
(
    input wire pclk,
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    output logic low_byte_mask,
    output logic high_byte_mask,
    output logic [15:0] dq_in
);
    // ====
    // Idle levels, then a link clock unrelated in phase to pclk
    initial
    begin
        {cs_n, ras_n, cas_n, we_n, cke, ba, addr} = {5'h1f, 15'h0};
        {high_byte_mask, low_byte_mask, dq_in} = 18'h0;
        ck = 1'b0;
        #1.3;
        forever #62.5 ck = ~ck;
    end
    // Seven pclk puts a change midway between two ck edges
    task automatic mid;
        repeat (7) @(posedge pclk);
    endtask
    // One command at a ck rise; k is the clock enable held with it
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k = 1'b1);
        @(negedge ck);
        mid();
        {cs_n, ras_n, cas_n, we_n} <= c;
        {ba, addr} <= {b, a};
        cke <= k;
        @(posedge ck);
        mid();
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        {ba, addr} <= ~{b, a};
        if (c == 4'h0)
            repeat (3) @(posedge ck);
    endtask
    // Write burst: beat i from d[16*i+:16], lane masks {high, low} from m[2*i+:2]
    task automatic wr(input logic [12:0] a, input int n, input logic [127:0] d, input logic [15:0] m);
        cmd(4'h4, 2'h0, a);
        for (int i = 0; i <= n; i++)
        begin
            @(ck);
            mid();
            dq_in <= (i == n) ? ~dq_in : d[16*i+:16];
            {high_byte_mask, low_byte_mask} <= (i == n) ? 2'h0 : m[2*i+:2];
        end
    endtask
endmodule

/* File: test/ddr_mode_burst_tb_top.sv */
// Bench: register window, mode loads, ordered bursts and lane masks.
// Assumes the model drives the link pins; ck has a 125 ns period.
`timescale 1ns/100ps
`include "ddr_mode_defs.vh"
module ddr_mode_burst_tb_top;
    logic pclk, presetn, psel, penable, pwrite, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, ck, cke, cs_n, ras_n, cas_n, we_n, low_byte_mask, high_byte_mask, dq_oe;
    wire [1:0] ba;
    wire [12:0] addr;
    wire [15:0] dq_in, dq_out;
    logic [15:0] mem [16];
    int n_fail = 0;
    int cmp_count = 0;
    ddr_mode_burst uut (.*);
    ddr_ctrl_model m (.*);
    // ====
    // Clock and shared checking tasks
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, g, x);
        end
    endtask
    task automatic close_out;
        $display("%0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One APB transfer held until pready is sampled high; judges error and read data
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, x, input logic xe);
        int t;
        t = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++t < 50);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        chk(pready, 1'b1);
        if (pready !== 1'b1)
            close_out();
        chk(e, xe);
        if (!w)
            chk(q, x);
    endtask
    // Read burst: count ck edges to the first beat, then judge beats mid-phase
    task automatic rd(input logic [3:0] s, input int bl, input logic il, input int hl);
        int n;
        logic [3:0] c, k;
        n = 0;
        k = bl[3:0] - 4'h1;
        m.cmd(4'h5, 2'h0, {9'h0, s});
        for (int i = -12; i < bl; i++)
        begin
            if (i < 0 && dq_oe !== 1'b1)
                n++;
            else if (i >= 0)
            begin
                c = il ? s ^ i[3:0] : (s & ~k) | ((s + i[3:0]) & k);
                chk(dq_out, mem[c]);
            end
            if (i < 0 && dq_oe === 1'b1)
                i = -1;
            else
            begin
                @(ck);
                repeat (9) @(posedge pclk);
            end
        end
        chk(n, hl);
        chk(dq_oe, 1'b0);
    endtask
    // Reset values, refused accesses and the control bit
    task automatic t_regs;
        acc(1'b0, `REG_MODE, 32'h0, 32'h0, 1'b0);
        acc(1'b0, `REG_STATUS, 32'h0, 32'h0000000c, 1'b0);
        acc(1'b0, `REG_CTRL, 32'h0, `CTRL_RESET, 1'b0);
        acc(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        acc(1'b1, `REG_MODE, 32'h22, 32'h0, 1'b1);
        acc(1'b0, `REG_MODE, 32'h0, 32'h0, 1'b0);
        $display("t_regs done");
    endtask
    // Field codes load and flag; decode-off and a low clock enable leave the mode alone
    task automatic t_mode;
        logic [12:0] md [6] = '{13'h022, 13'h03b, 13'h060, 13'h011, 13'h0a1, 13'h121};
        logic [3:0] st [6] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        for (int i = 0; i < 6; i++)
        begin
            m.cmd(4'h0, 2'h0, md[i]);
            acc(1'b0, `REG_MODE, 32'h0, {19'h0, md[i]}, 1'b0);
            acc(1'b0, `REG_STATUS, 32'h0, {26'h0, st[i], 2'h1}, 1'b0);
        end
        m.cmd(4'h0, 2'h1, 13'h0002);
        acc(1'b0, `REG_EXT_MODE, 32'h0, 32'h2002, 1'b0);
        acc(1'b1, `REG_CTRL, 32'h0, 32'h0, 1'b0);
        m.cmd(4'h0, 2'h0, 13'h0022);
        acc(1'b1, `REG_CTRL, 32'h1, 32'h0, 1'b0);
        m.cmd(4'hf, 2'h0, 13'h0000, 1'b0);
        m.cmd(4'h0, 2'h0, 13'h0022);
        acc(1'b0, `REG_MODE, 32'h0, 32'h121, 1'b0);
        // Sticky DLL reset request clears by writing one to its status bit
        acc(1'b1, `REG_STATUS, 32'h20, 32'h0, 1'b0);
        acc(1'b0, `REG_STATUS, 32'h0, 32'h3, 1'b0);
        $display("t_mode done");
    endtask
    // Fill the store, then read in each order, length and latency
    task automatic t_burst;
        logic [127:0] d;
        int md [6] = '{'h033, 'h03b, 'h022, 'h06a, 'h021, 'h029};
        int st [6] = '{5, 13, 7, 1, 11, 2};
        int hl [6] = '{6, 6, 4, 5, 4, 4};
        m.cmd(4'h0, 2'h0, 13'h0033);
        for (int k = 0; k < 16; k++)
            mem[k] = 16'hc300 ^ (16'h1111 * k[15:0]);
        for (int h = 0; h < 2; h++)
        begin
            for (int k = 0; k < 8; k++)
                d[16*k+:16] = mem[8*h+k];
            m.wr(13'h008 * h[12:0], 8, d, 16'h0);
        end
        for (int i = 0; i < 6; i++)
        begin
            m.cmd(4'h0, 2'h0, md[i][12:0]);
            rd(st[i][3:0], 1 << md[i][1:0], md[i][3], hl[i]);
        end
        $display("t_burst done");
    endtask
    // Each lane mask blocks only its own byte of one beat
    task automatic t_mask;
        m.cmd(4'h0, 2'h0, 13'h0021);
        m.wr(13'h004, 2, {96'h0, 16'h5aa5, 16'h9669}, 16'h0009);
        mem[4] = {8'h96, mem[4][7:0]};
        mem[5] = {mem[5][15:8], 8'ha5};
        rd(4'h4, 2, 1'b0, 4);
        // Burst stop inside the latency: no beat may follow it
        m.cmd(4'h5, 2'h0, 13'h0004);
        m.cmd(4'h6, 2'h0, 13'h0000);
        repeat (3) @(ck);
        repeat (9) @(posedge pclk);
        chk(dq_oe, 1'b0);
        acc(1'b0, `REG_STATUS, 32'h0, 32'h3, 1'b0);
        $display("t_mask done");
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mode();
        t_burst();
        t_mask();
        close_out();
    end
endmodule
bind ddr_mode_burst ddr_mode_burst_sva chk_i (.*);
